// ### uep_pkg.sv
package uep_pkg;
	// Clock 10 MHz
	localparam int unsigned CLK_PERIOD_NS = 100;
	// Program pulse, nominal and ceiling
	localparam int unsigned PULSE_NOM_MS = 10;
	localparam int unsigned PULSE_MAX_MS = 55;
	localparam int unsigned PULSE_CYC = PULSE_NOM_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_MS * 1000000 / CLK_PERIOD_NS;
	// Setup and hold around the pulse
	localparam int unsigned SETUP_US = 2;
	localparam int unsigned HOLD_US = 2;
	localparam int unsigned SETUP_CYC = (SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HOLD_CYC = (HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Read access, slow grade covers all three
	localparam int unsigned ADDR_ACCESS_NS = 450;
	localparam int unsigned SEL_ACCESS_NS = 150;
	localparam int unsigned STROBE_ACCESS_NS = 450;
	localparam int unsigned ACCESS_NS = ADDR_ACCESS_NS;
	localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	// Output release after select high
	localparam int unsigned REL_READ_NS = 100;
	localparam int unsigned REL_PROG_NS = 120;
	localparam int unsigned REL_CYC = (REL_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 20;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage : uep_pkg

// ### uep_host.sv
`timescale 1ns/1ns
`default_nettype none
module uep_host
	import uep_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = PULSE_CYC,
	parameter int unsigned PULSE_MAX_CYCLES = PULSE_MAX_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_write,
	input wire logic [10:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	input wire logic [3:0] cmd_enable,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_mismatch,
	output logic rsp_zero_to_one,
	// Device pins
	output logic [10:0] address,
	output logic [3:0] select_n,
	output logic [3:0] program_powerdown_strobe,
	output logic vpp_high,
	input wire logic [7:0] byte_lines_in,
	output logic [7:0] byte_lines_out,
	output logic byte_lines_oe_n
);
	typedef enum logic [2:0] {
		UEP_IDLE, UEP_SETUP, UEP_PULSE, UEP_HOLD, UEP_RELEASE, UEP_ACCESS, UEP_DONE
	} uep_state_t;
	uep_state_t state;
	uep_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic is_write;
	logic [7:0] wdata;
	logic [3:0] enab;
	logic cnt_done;
	logic [CNT_W-1:0] state_len;
	assign cmd_ready = (state == UEP_IDLE);
	assign cnt_done = (cnt == state_len - 1'b1);
	always_comb begin
		unique case (state)
			UEP_SETUP: state_len = CNT_W'(SETUP_CYC);
			UEP_PULSE: state_len = CNT_W'(PULSE_CYCLES);
			UEP_HOLD: state_len = CNT_W'(HOLD_CYC);
			UEP_RELEASE: state_len = CNT_W'(REL_CYC);
			UEP_ACCESS: state_len = CNT_W'(ACCESS_CYC);
			default: state_len = CNT_W'(1);
		endcase
	end
	always_comb begin
		next_state = state;
		unique case (state)
			UEP_IDLE: if (cmd_valid) next_state = UEP_SETUP;
			UEP_SETUP: if (cnt_done) next_state = is_write ? UEP_PULSE : UEP_ACCESS;
			UEP_PULSE: if (cnt_done) next_state = UEP_HOLD;
			UEP_HOLD: if (cnt_done) next_state = UEP_RELEASE;
			UEP_RELEASE: if (cnt_done) next_state = UEP_ACCESS;
			UEP_ACCESS: if (cnt_done) next_state = UEP_DONE;
			UEP_DONE: next_state = UEP_IDLE;
			default: next_state = UEP_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= UEP_IDLE;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= (next_state != state) ? '0 : cnt + 1'b1;
		end
	end
	// Any address order, any enable set
	always_ff @(posedge clk) begin
		if (rst) begin
			is_write <= 1'b0;
			wdata <= ERASED_BYTE;
			enab <= '0;
			address <= '0;
		end else if (state == UEP_IDLE && cmd_valid) begin
			is_write <= cmd_write;
			wdata <= cmd_data;
			enab <= cmd_enable;
			address <= cmd_addr;
		end
	end
	// Pin drive per device: inhibited ones keep strobe low and select high
	logic prog_phase;
	assign prog_phase = is_write && (state == UEP_SETUP || state == UEP_PULSE ||
		state == UEP_HOLD);
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_dev
			logic sel_low;
			logic strobe_hi;
			assign sel_low = enab[gi] && !prog_phase && state != UEP_IDLE &&
				state != UEP_RELEASE;
			assign strobe_hi = (state == UEP_IDLE) || (state == UEP_PULSE && enab[gi]);
			always_ff @(posedge clk) begin
				if (rst) begin
					select_n[gi] <= 1'b1;
					program_powerdown_strobe[gi] <= 1'b1;
				end else begin
					select_n[gi] <= !sel_low;
					program_powerdown_strobe[gi] <= strobe_hi;
				end
			end
		end
	endgenerate
	// Supply held high through verify so read-back follows at once
	always_ff @(posedge clk) begin
		if (rst) begin
			vpp_high <= 1'b0;
			byte_lines_out <= ERASED_BYTE;
			byte_lines_oe_n <= 1'b1;
		end else begin
			vpp_high <= is_write && state != UEP_IDLE && state != UEP_DONE;
			byte_lines_out <= wdata;
			byte_lines_oe_n <= !prog_phase;
		end
	end
	// Sample only after full access time; nothing kept from the last address
	logic sample;
	assign sample = (state == UEP_ACCESS) && cnt_done;
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			rsp_mismatch <= 1'b0;
			rsp_zero_to_one <= 1'b0;
		end else begin
			rsp_valid <= sample;
			if (sample) begin
				rsp_data <= byte_lines_in;
				rsp_mismatch <= is_write && (byte_lines_in != wdata);
				rsp_zero_to_one <= is_write && |(wdata & ~byte_lines_in);
			end
		end
	end
	// Release wait covers the longer program-side disable
	property p_pulse_len;
		@(posedge clk) disable iff (rst)
		$rose(program_powerdown_strobe[0]) && prog_phase |-> program_powerdown_strobe[0] [*8];
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse short");
	logic [CNT_W-1:0] hi_cnt;
	always_ff @(posedge clk) begin
		if (rst || state == UEP_IDLE) hi_cnt <= '0;
		else if (program_powerdown_strobe[0]) hi_cnt <= hi_cnt + 1'b1;
	end
	property p_pulse_max;
		@(posedge clk) disable iff (rst) hi_cnt <= CNT_W'(PULSE_MAX_CYCLES);
	endproperty
	a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
	property p_drive_prog;
		@(posedge clk) disable iff (rst) !byte_lines_oe_n |-> &select_n;
	endproperty
	a_drive_prog: assert property (p_drive_prog) else $error("drive with select low");
	property p_inhibit;
		@(posedge clk) disable iff (rst)
		(state == UEP_HOLD && !enab[1]) |-> !program_powerdown_strobe[1] && select_n[1];
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibit broken");
	property p_vpp;
		@(posedge clk) disable iff (rst) (program_powerdown_strobe[0] && state != UEP_IDLE &&
			$past(state) != UEP_IDLE) |-> vpp_high;
	endproperty
	a_vpp: assert property (p_vpp) else $error("pulse without supply");
	property p_access;
		@(posedge clk) disable iff (rst) rsp_valid |-> $past(state) == UEP_ACCESS;
	endproperty
	a_access: assert property (p_access) else $error("early sample");
	property p_read_sel;
		@(posedge clk) disable iff (rst) sample && enab[0] |-> !select_n[0] &&
			!program_powerdown_strobe[0];
	endproperty
	a_read_sel: assert property (p_read_sel) else $error("read pins wrong");
	property p_idle_pd;
		@(posedge clk) disable iff (rst) (state == UEP_IDLE && $past(state) == UEP_IDLE) |->
			&program_powerdown_strobe;
	endproperty
	a_idle_pd: assert property (p_idle_pd) else $error("idle not powered down");
	// Exact length; the extra count is the power-down level left in the first setup cycle
	property p_pulse_exact;
		@(posedge clk) disable iff (rst)
		$fell(program_powerdown_strobe[0]) && state == UEP_HOLD |->
			hi_cnt == CNT_W'(PULSE_CYCLES + 1);
	endproperty
	a_pulse_exact: assert property (p_pulse_exact) else $error("pulse length off");
	property p_turn;
		@(posedge clk) disable iff (rst) $fell(byte_lines_oe_n) |-> $past(&select_n);
	endproperty
	a_turn: assert property (p_turn) else $error("host drives over selected device");
	property p_read_vpp;
		@(posedge clk) disable iff (rst) state == UEP_ACCESS && !is_write |-> !vpp_high;
	endproperty
	a_read_vpp: assert property (p_read_vpp) else $error("supply high on plain read");
	c_write: cover property (@(posedge clk) rsp_valid && is_write);
	c_read: cover property (@(posedge clk) rsp_valid && !is_write);
	c_mis: cover property (@(posedge clk) rsp_valid && rsp_mismatch);
	c_inhibit: cover property (@(posedge clk) state == UEP_PULSE && enab[0] && !enab[1]);
endmodule : uep_host
`default_nettype wire

// ### uep_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module uep_dev_model (
	// Device pins
	input wire logic [10:0] address,
	input wire logic [3:0] select_n,
	input wire logic [3:0] program_powerdown_strobe,
	input wire logic vpp_high,
	// Host side of the shared byte lines
	input wire logic [7:0] host_data,
	input wire logic host_oe_n,
	output logic [7:0] byte_lines
);
	logic [7:0] mem [4][2048];
	logic [3:0] rd_en;
	logic [7:0] rd_val;
	logic [7:0] last;
	wire drv;
	initial begin
		foreach (mem[i, j]) mem[i][j] = 8'hff; // Erased cells read one
		last = 8'h00;
	end
	for (genvar i = 0; i < 4; i++) begin : g_dev
		assign rd_en[i] = ~select_n[i] & ~program_powerdown_strobe[i];
		logic armed = 1'b0;
		// Only a pulse that rose in program mode stores, at its end; leaving power-down does not
		always @(posedge program_powerdown_strobe[i] or negedge program_powerdown_strobe[i]) begin
			if (program_powerdown_strobe[i] === 1'b1) begin
				armed = (vpp_high === 1'b1 && select_n[i] === 1'b1);
			end else begin
				if (armed && vpp_high === 1'b1 && select_n[i] === 1'b1) begin
					mem[i][address] &= byte_lines;
				end
				armed = 1'b0;
			end
		end
	end
	always_comb begin
		rd_val = 8'hff;
		for (int i = 0; i < 4; i++) if (rd_en[i]) rd_val &= mem[i][address];
	end
	// Slow access on enable, fast release on disable
	assign #(450, 100) drv = |rd_en;
	always @(rd_val or host_data or drv or host_oe_n) begin
		if (!host_oe_n) last = host_data;
		else if (drv) last = rd_val;
	end
	// No pull-ups: an undriven bus shows the inverse of its last value
	assign byte_lines = !host_oe_n ? host_data : (drv ? rd_val : ~last);
endmodule : uep_dev_model
`default_nettype wire

// ### uep_host_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module uep_host_tb_top;
	import uep_pkg::*;
	logic clk = 0, rst = 1, cmd_valid = 0, cmd_write = 0;
	logic [10:0] cmd_addr = '0;
	logic [7:0] cmd_data = '0;
	logic [3:0] cmd_enable = '0;
	wire cmd_ready, rsp_valid, rsp_mismatch, rsp_zero_to_one, vpp_high, oe_n;
	wire [7:0] rsp_data, bl_in, bl_out;
	wire [10:0] address;
	wire [3:0] select_n, strobe;
	int err_total = 0, samples_checked = 0;
	logic [7:0] rd;
	logic mm, z1;
	initial forever #50 clk = ~clk;
	uep_host #(.PULSE_CYCLES(16), .PULSE_MAX_CYCLES(64)) i_dut (.clk(clk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_enable(cmd_enable),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_mismatch(rsp_mismatch),
		.rsp_zero_to_one(rsp_zero_to_one), .address(address), .select_n(select_n),
		.program_powerdown_strobe(strobe), .vpp_high(vpp_high), .byte_lines_in(bl_in),
		.byte_lines_out(bl_out), .byte_lines_oe_n(oe_n));
	uep_dev_model i_dev (.address(address), .select_n(select_n),
		.program_powerdown_strobe(strobe), .vpp_high(vpp_high), .host_data(bl_out),
		.host_oe_n(oe_n), .byte_lines(bl_in));
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	// One request, then wait a bounded time for its single-cycle answer
	task automatic cmd(input logic w, input logic [10:0] a, input logic [7:0] d,
		input logic [3:0] en);
		int n;
		@(negedge clk);
		{cmd_write, cmd_addr, cmd_data, cmd_enable} = {w, a, d, en};
		cmd_valid = 1;
		n = 0;
		// Ready is settled here and stands until the edge that takes the request
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		cmd_valid = 0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
		if (n >= 500) chk("rsp_valid", 8'h00, 8'h01);
		{rd, mm, z1} = {rsp_data, rsp_mismatch, rsp_zero_to_one};
	endtask : cmd
	task automatic t_reset;
		chk("select_n", {4'h0, select_n}, 8'h0f);
		chk("strobe", {4'h0, strobe}, 8'h0f);
		chk("vpp oe", {6'h00, vpp_high, oe_n}, 8'h01);
	endtask : t_reset
	task automatic t_parallel;
		cmd(1, 11'h7ff, 8'h5a, 4'h5);
		chk("verify", rd, 8'h5a);
		chk("flags", {6'h00, mm, z1}, 8'h00);
		cmd(0, 11'h7ff, 8'h00, 4'h2);
		chk("inhibited", rd, 8'hff);
		cmd(0, 11'h7ff, 8'h00, 4'h4);
		chk("dev2 read", rd, 8'h5a);
	endtask : t_parallel
	task automatic t_zero_to_one;
		cmd(1, 11'h7ff, 8'h0f, 4'h1);
		chk("anded", rd, 8'h0a);
		chk("flags", {6'h00, mm, z1}, 8'h03);
	endtask : t_zero_to_one
	task automatic t_order;
		cmd(1, 11'h000, 8'h3c, 4'h8);
		cmd(1, 11'h400, 8'hc3, 4'h8);
		cmd(0, 11'h000, 8'h00, 4'h8);
		chk("low addr", rd, 8'h3c);
		cmd(0, 11'h400, 8'h00, 4'h8);
		chk("mid addr", rd, 8'hc3);
	endtask : t_order
	initial begin
		#2000000;
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		t_reset();
		t_parallel();
		t_zero_to_one();
		t_order();
		wrap_up();
	end
endmodule : uep_host_tb_top
`default_nettype wire
